// ==== dv/ufb_far_end.sv ====
`timescale 1ns/1ps
module ufb_far_end (
    input wire logic pclk,
    input wire logic txd,
    output logic rxd,
    output logic sync_serial_clock
);
    initial rxd = 1'b1;
    initial sync_serial_clock = 1'b0;
    // sync frame: clock held still outside it, rxd moves after the change edge,
    // txd taken just before the sample edge
    task sync_xfer(input logic [8:0] d, input int nb, input logic pol, output logic [10:0] f);
        logic b;
        f = 11'h7ff;
        sync_serial_clock <= pol;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < nb + 2; i++) begin
            b = (i == 0) ? 1'b0 : (i > nb) ? 1'b1 : d[i - 1];
            sync_serial_clock <= ~pol;
            repeat (4) @(posedge pclk);
            rxd <= b;
            repeat (4) @(posedge pclk);
            f[i] = txd;
            sync_serial_clock <= pol;
            repeat (8) @(posedge pclk);
        end
    endtask
    // start, data lsb first, always a single stop bit
    task send(input logic [8:0] d, input int nb, input int per, input int gap);
        repeat (gap) @(posedge pclk);
        rxd <= 1'b0;
        repeat (per) @(posedge pclk);
        for (int i = 0; i < nb; i++) begin
            rxd <= d[i];
            repeat (per) @(posedge pclk);
        end
        rxd <= 1'b1;
        repeat (per) @(posedge pclk);
    endtask
    // decodes one frame, measures start to next start
    task grab(input int nb, input int per, output logic [8:0] d, output int len, output int w);
        d = 9'h000;
        w = 0;
        len = 0;
        while (txd !== 1'b0) begin
            @(negedge pclk);
            w++;
        end
        do begin
            @(negedge pclk);
            len++;
            if (len % per == per / 2 && len / per >= 1 && len / per <= nb)
                d[len / per - 1] = txd;
        end while (txd !== 1'b0 || len <= (nb + 1) * per);
    endtask
endmodule // ufb_far_end

// ==== dv/ufb_uart_bench.sv ====
`timescale 1ns/1ps
module ufb_uart_bench;
    typedef struct packed {
        logic [7:0] cb;
        logic [7:0] cc;
        logic [7:0] ca;
        logic [7:0] dl;
        logic [8:0] d;
    } ufb_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire [31:0] prdata;
    wire pready, pslverr, txd, rxd, sync_serial_clock;
    logic [8:0] got;
    logic [10:0] sf;
    logic [7:0] tb, rb;
    int fail_count = 0, comparisons = 0, len, nb, st, per, k;
    ufb_row_t rows [6] = '{'{8'h08, 8'h00, 8'h00, 8'h00, 9'h015},
        '{8'h08, 8'h0a, 8'h02, 8'h00, 9'h02a}, '{8'h08, 8'h04, 8'h00, 8'h01, 9'h05b},
        '{8'h08, 8'h0e, 8'h02, 8'h01, 9'h0c3}, '{8'h0d, 8'h06, 8'h00, 8'h00, 9'h1a5},
        '{8'h0c, 8'h02, 8'h00, 8'h00, 9'h0ff}};
    always #2.5 pclk = ~pclk;
    ufb_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .txd(txd), .rxd(rxd), .sync_serial_clock_o(),
        .sync_serial_clock_i(sync_serial_clock), .sync_serial_clock_oe());
    ufb_far_end far (.pclk(pclk), .txd(txd), .rxd(rxd), .sync_serial_clock(sync_serial_clock));
    task cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
            fail_count++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) fail_count++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask
    task idle(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, 12'h014, 32'h0);
            n++;
        end while ((rd & m) != 0 && n < 500);
        if (n >= 500) fail_count++;
    endtask
    task complete_run;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        complete_run;
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(12'h000, 32'h0);
        chk(12'h00c, 32'h6);
        chk(12'h010, 32'h0);
        apb(1'b1, 12'h004, 32'hffffff0f);
        chk(12'h004, 32'h0000000f);
        apb(1'b1, 12'h000, 32'h000001ab);
        chk(12'h000, 32'h000000ab);
        apb(1'b1, 12'h020, 32'h12345678);
        chk(12'h020, 32'h0);
        for (int i = 0; i < 6; i++) begin
            k = {rows[i].cb[2], rows[i].cc[2:1]};
            nb = (k == 7) ? 9 : (k > 3) ? 8 : k + 5;
            st = rows[i].cc[3] + 1;
            per = (rows[i].dl + 1) * (rows[i].ca[1] ? 8 : 16);
            apb(1'b1, 12'h008, {24'h0, rows[i].cb});
            apb(1'b1, 12'h00c, {24'h0, rows[i].cc});
            apb(1'b1, 12'h010, {24'h0, rows[i].ca});
            apb(1'b1, 12'h004, 32'h0);
            apb(1'b1, 12'h000, {24'h0, rows[i].dl});
            fork
                far.grab(nb, per, got, len, k);
                begin
                    apb(1'b1, 12'h018, {24'h0, rows[i].d[7:0]});
                    apb(1'b1, 12'h018, {24'h0, rows[i].d[7:0]});
                end
            join
            cmp(32'(k < 2 * per + 8), 32'h1);
            cmp({23'h0, got}, 32'(rows[i].d) & ((32'h1 << nb) - 1));
            cmp(32'(len), 32'((1 + nb + st) * per));
            idle(32'h21);
        end
        apb(1'b1, 12'h008, 32'h18);
        apb(1'b1, 12'h00c, 32'h0e);
        apb(1'b1, 12'h010, 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        far.send(9'h05a, 8, 16, 1);
        far.send(9'h0a5, 8, 16, 1);
        far.send(9'h03c, 8, 16, 40);
        idle(32'h10);
        apb(1'b0, 12'h014, 32'h0);
        cmp(rd & 32'h0c, 32'h04);
        chk(12'h01c, 32'h5a);
        chk(12'h01c, 32'ha5);
        apb(1'b0, 12'h014, 32'h0);
        cmp(rd & 32'h04, 32'h0);
        for (int p = 0; p < 2; p++) begin
            tb = p ? 8'h69 : 8'h96;
            rb = p ? 8'h3c : 8'hc3;
            apb(1'b1, 12'h00c, 32'h46 | p);
            apb(1'b1, 12'h018, {24'h0, tb});
            far.sync_xfer({1'b0, rb}, 8, p[0], sf);
            cmp({21'h0, sf}, {21'h0, 2'h3, tb, 1'b0});
            chk(12'h01c, {24'h0, rb});
        end
        apb(1'b1, 12'h000, 32'h33);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(12'h000, 32'h0);
        chk(12'h00c, 32'h6);
        complete_run;
    end
endmodule // ufb_uart_bench
bind ufb_uart ufb_uart_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd(txd), .sync_serial_clock_o(sync_serial_clock_o),
    .sync_serial_clock_oe(sync_serial_clock_oe));

// ==== dv/ufb_uart_properties.sv ====
`timescale 1ns/1ps
module ufb_uart_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic txd,
    input wire logic sync_serial_clock_o,
    input wire logic sync_serial_clock_oe
);
    logic wr, rd;
    logic [7:0] lo_q;
    logic [3:0] hi_q;
    logic cw_q, en_q;
    assign wr = psel && penable && pwrite && pready;
    assign rd = psel && penable && !pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_q <= 8'h00;
            hi_q <= 4'h0;
            cw_q <= 1'b0;
            en_q <= 1'b0;
        end else if (wr) begin
            if (paddr == 12'h000) lo_q <= pwdata[7:0];
            if (paddr == 12'h004) hi_q <= pwdata[3:0];
            if (paddr == 12'h00c) cw_q <= 1'b1;
            if (paddr == 12'h008) en_q <= en_q | pwdata[3];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not answered at once");
    a_low_readback: assert property (rd && paddr == 12'h000 |->
        prdata == {24'h0, lo_q}) else $error("divisor low readback wrong");
    a_high_readback: assert property (rd && paddr == 12'h004 |->
        prdata == {28'h0, hi_q}) else $error("divisor high readback wrong");
    a_ctrl_c_reset: assert property (rd && paddr == 12'h00c && !cw_q |->
        prdata == 32'h6) else $error("control c reset value wrong");
    a_line_idle: assert property (!en_q |-> txd)
        else $error("line left idle level");
    a_clock_released: assert property (!sync_serial_clock_oe && !sync_serial_clock_o)
        else $error("serial clock driven");
    a_low_bit_width: assert property ($fell(txd) && lo_q == 0 && hi_q == 0 |=>
        !txd [*7]) else $error("low bit too short");
    a_high_bit_width: assert property ($rose(txd) && lo_q == 0 && hi_q == 0 |=>
        txd [*7]) else $error("high bit too short");
endmodule // ufb_uart_properties

// ==== logic/ufb_buf2.v ====
`timescale 1ns/1ps
module ufb_buf2 (
    input wire pclk,
    input wire presetn,
    input wire in_valid,
    output wire in_ready,
    input wire [8:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [8:0] out_data
);
    reg [8:0] mem_q [0:1];
    reg rd_q;
    reg wr_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_q[0] <= 9'h000;
            mem_q[1] <= 9'h000;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'h1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'h1;
            end
        end
    end
endmodule // ufb_buf2

// ==== logic/ufb_defs.vh ====
`ifndef UFB_DEFS_VH
`define UFB_DEFS_VH

// register byte addresses
`define UFB_ADDR_BAUD_LOW 12'h000
`define UFB_ADDR_BAUD_HIGH 12'h004
`define UFB_ADDR_CTRL_B 12'h008
`define UFB_ADDR_CTRL_C 12'h00c
`define UFB_ADDR_CTRL_A 12'h010
`define UFB_ADDR_STATUS 12'h014
`define UFB_ADDR_TXDATA 12'h018
`define UFB_ADDR_RXDATA 12'h01c

// reset values
`define UFB_BAUD_LOW_RST 8'h00
`define UFB_BAUD_HIGH_RST 4'h0
`define UFB_CTRL_B_RST 8'h00
`define UFB_CTRL_C_RST 8'h06
`define UFB_CTRL_A_RST 8'h00

// control b fields
`define UFB_B_RX_EN 4
`define UFB_B_TX_EN 3
`define UFB_B_SIZE_HI 2
`define UFB_B_TX_BIT8 0
// control c fields
`define UFB_C_SYNC_MODE 6
`define UFB_C_STOP_SEL 3
`define UFB_C_SIZE_LO_H 2
`define UFB_C_SIZE_LO_L 1
`define UFB_C_EDGE_SEL 0
// control a fields
`define UFB_A_DOUBLE 1

// character size codes
`define UFB_SIZE_5 3'h0
`define UFB_SIZE_6 3'h1
`define UFB_SIZE_7 3'h2
`define UFB_SIZE_8 3'h3
`define UFB_SIZE_9 3'h7

// oversampling
`define UFB_OVS_NORMAL 5'h10
`define UFB_OVS_DOUBLE 5'h08

`endif

// ==== logic/ufb_uart.v ====
// How it works
// - the transmitter sends one stop bit when stop_count_select is 0 and two when it is 1.
// - char size is a 3-bit code, 000..011 give 5..8 bits, 111 gives 9, 100..110 reserved.
// - synchronous polarity 0 changes tx on rising clock and samples rx on falling; 1 swaps.
// - the divisor is 12 bits, upper four in the high register, lower eight in the low one.
// - a write to the low divisor byte reloads the prescaler at once.
// - divisor zero gives the top rate, clock/16 normally and clock/8 in double speed.
// - in asynchronous operation double speed cuts oversampling from 16 to 8.
// - the stop-bit count affects only the transmitter, the receiver ignores it.
`timescale 1ns/1ps
`include "ufb_defs.vh"
module ufb_uart (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output reg txd,
    input wire rxd,
    output reg sync_serial_clock_o,
    input wire sync_serial_clock_i,
    output wire sync_serial_clock_oe
);
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;

    reg [7:0] baud_divisor_low_q;
    reg [3:0] baud_divisor_high_q;
    reg [7:0] serial_control_b_q;
    reg [7:0] serial_control_c_q;
    reg [7:0] ctrl_a_q;
    reg [11:0] presc_q;
    reg [4:0] ovs_q;
    reg bit_tick;
    reg [1:0] tx_st_q;
    reg [8:0] tx_sh_q;
    reg [3:0] tx_cnt_q;
    reg [1:0] rx_st_q;
    reg [8:0] rx_sh_q;
    reg [3:0] rx_cnt_q;
    reg [4:0] rx_ph_q;
    reg rx_s1_q;
    reg rx_s2_q;
    reg xck_s1_q;
    reg xck_s2_q;
    reg xck_d_q;
    reg frame_err_q;
    wire wr;
    wire rd;
    wire [11:0] baud_divisor;
    wire sync_mode;
    wire dbl;
    wire [3:0] nbits;
    wire [4:0] ovs_top;
    wire presc_tick;
    wire xck_rise;
    wire xck_fall;
    wire tx_shift_edge;
    wire rx_sample_edge;
    wire txb_valid;
    wire txb_ready;
    wire [8:0] txb_data;
    wire txq_valid;
    reg txq_ready;
    wire [8:0] txq_data;
    reg rxb_valid;
    wire rxb_ready;
    wire rxq_valid;
    wire rxq_ready;
    wire [8:0] rxq_data;

    function [3:0] size_bits;
        input [2:0] code;
        begin
            case (code)
                `UFB_SIZE_5: size_bits = 4'h5;
                `UFB_SIZE_6: size_bits = 4'h6;
                `UFB_SIZE_7: size_bits = 4'h7;
                `UFB_SIZE_8: size_bits = 4'h8;
                `UFB_SIZE_9: size_bits = 4'h9;
                default: size_bits = 4'h8;
            endcase
        end
    endfunction

    assign wr = psel && penable && pwrite;
    assign rd = psel && !pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign baud_divisor = {baud_divisor_high_q, baud_divisor_low_q};
    assign sync_mode = serial_control_c_q[`UFB_C_SYNC_MODE];
    assign dbl = ctrl_a_q[`UFB_A_DOUBLE] && !sync_mode;
    assign nbits = size_bits({serial_control_b_q[`UFB_B_SIZE_HI],
        serial_control_c_q[`UFB_C_SIZE_LO_H:`UFB_C_SIZE_LO_L]});
    assign ovs_top = dbl ? `UFB_OVS_DOUBLE : `UFB_OVS_NORMAL;
    assign presc_tick = (presc_q == 12'h000);
    assign txb_valid = wr && (paddr == `UFB_ADDR_TXDATA);
    assign rxq_ready = psel && penable && rd && (paddr == `UFB_ADDR_RXDATA);
    assign sync_serial_clock_oe = 1'b0;

    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_divisor_low_q <= `UFB_BAUD_LOW_RST;
            baud_divisor_high_q <= `UFB_BAUD_HIGH_RST;
            serial_control_b_q <= `UFB_CTRL_B_RST;
            serial_control_c_q <= `UFB_CTRL_C_RST;
            ctrl_a_q <= `UFB_CTRL_A_RST;
        end else if (wr) begin
            case (paddr)
                `UFB_ADDR_BAUD_LOW: baud_divisor_low_q <= pwdata[7:0];
                `UFB_ADDR_BAUD_HIGH: baud_divisor_high_q <= pwdata[3:0];
                `UFB_ADDR_CTRL_B: serial_control_b_q <= pwdata[7:0];
                `UFB_ADDR_CTRL_C: serial_control_c_q <= {1'b0, pwdata[6:0]};
                `UFB_ADDR_CTRL_A: ctrl_a_q <= {6'h00, pwdata[1], 1'b0};
                default: ctrl_a_q <= ctrl_a_q;
            endcase
        end
    end

    // read mux
    always @* begin
        prdata = 32'h0000_0000;
        case (paddr)
            `UFB_ADDR_BAUD_LOW: prdata = {24'h000000, baud_divisor_low_q};
            `UFB_ADDR_BAUD_HIGH: prdata = {28'h0000000, baud_divisor_high_q};
            `UFB_ADDR_CTRL_B: prdata = {24'h000000, serial_control_b_q};
            `UFB_ADDR_CTRL_C: prdata = {24'h000000, serial_control_c_q};
            `UFB_ADDR_CTRL_A: prdata = {24'h000000, ctrl_a_q};
            `UFB_ADDR_STATUS: prdata = {26'h0, tx_st_q != ST_IDLE,
                rx_st_q != ST_IDLE, frame_err_q, rxq_valid, txb_ready, txq_valid};
            `UFB_ADDR_RXDATA: prdata = {23'h0, rxq_data};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // prescaler and oversampling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= 12'h000;
            ovs_q <= 5'h00;
            bit_tick <= 1'b0;
        end else begin
            bit_tick <= 1'b0;
            if (wr && paddr == `UFB_ADDR_BAUD_LOW) begin
                presc_q <= {baud_divisor_high_q, pwdata[7:0]};
                ovs_q <= 5'h00;
            end else if (presc_tick) begin
                presc_q <= baud_divisor;
                if (ovs_q == ovs_top - 5'h01) begin
                    ovs_q <= 5'h00;
                    bit_tick <= 1'b1;
                end else begin
                    ovs_q <= ovs_q + 5'h01;
                end
            end else begin
                presc_q <= presc_q - 12'h001;
            end
        end
    end

    // synchronous clock edges, pins synchronised through two flops first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xck_s1_q <= 1'b0;
            xck_s2_q <= 1'b0;
            xck_d_q <= 1'b0;
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            sync_serial_clock_o <= 1'b0;
        end else begin
            xck_s1_q <= sync_serial_clock_i;
            xck_s2_q <= xck_s1_q;
            xck_d_q <= xck_s2_q;
            rx_s1_q <= rxd;
            rx_s2_q <= rx_s1_q;
            sync_serial_clock_o <= 1'b0;
        end
    end
    assign xck_rise = xck_s2_q && !xck_d_q;
    assign xck_fall = !xck_s2_q && xck_d_q;
    assign tx_shift_edge = sync_mode ?
        (serial_control_c_q[`UFB_C_EDGE_SEL] ? xck_fall : xck_rise) : bit_tick;
    assign rx_sample_edge = serial_control_c_q[`UFB_C_EDGE_SEL] ? xck_rise : xck_fall;

    ufb_buf2 u_txbuf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(txb_valid),
        .in_ready(txb_ready),
        .in_data(txb_data),
        .out_valid(txq_valid),
        .out_ready(txq_ready),
        .out_data(txq_data)
    );
    assign txb_data = {serial_control_b_q[`UFB_B_TX_BIT8], pwdata[7:0]};

    // transmitter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_q <= ST_IDLE;
            tx_sh_q <= 9'h000;
            tx_cnt_q <= 4'h0;
            txd <= 1'b1;
        end else if (tx_shift_edge) begin
            case (tx_st_q)
                ST_IDLE: begin
                    txd <= 1'b1;
                    if (txq_valid && serial_control_b_q[`UFB_B_TX_EN]) begin
                        tx_sh_q <= txq_data;
                        txd <= 1'b0;
                        tx_cnt_q <= 4'h0;
                        tx_st_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    txd <= tx_sh_q[0];
                    tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                    if (tx_cnt_q == nbits - 4'h1) begin
                        tx_cnt_q <= 4'h0;
                        tx_st_q <= ST_STOP;
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                    end
                end
                ST_STOP: begin
                    txd <= 1'b1;
                    if (tx_cnt_q == {3'h0, serial_control_c_q[`UFB_C_STOP_SEL]}) begin
                        tx_st_q <= ST_IDLE;
                    end else begin
                        tx_cnt_q <= tx_cnt_q + 4'h1;
                    end
                end
                default: tx_st_q <= ST_IDLE;
            endcase
        end
    end
    always @* begin
        txq_ready = tx_shift_edge && (tx_st_q == ST_IDLE) && serial_control_b_q[`UFB_B_TX_EN];
    end

    // receiver, one stop bit checked regardless of stop select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_st_q <= ST_IDLE;
            rx_sh_q <= 9'h000;
            rx_cnt_q <= 4'h0;
            rx_ph_q <= 5'h00;
            frame_err_q <= 1'b0;
            rxb_valid <= 1'b0;
        end else begin
            rxb_valid <= 1'b0;
            if (!serial_control_b_q[`UFB_B_RX_EN]) begin
                rx_st_q <= ST_IDLE;
            end else if (sync_mode ? rx_sample_edge :
                (presc_tick && !(wr && paddr == `UFB_ADDR_BAUD_LOW))) begin
                rx_ph_q <= rx_ph_q + 5'h01;
                case (rx_st_q)
                    ST_IDLE: begin
                        if (!rx_s2_q) begin
                            rx_st_q <= sync_mode ? ST_DATA : ST_START;
                            rx_ph_q <= 5'h00;
                            rx_cnt_q <= 4'h0;
                            rx_sh_q <= 9'h000;
                        end
                    end
                    ST_START: begin
                        if (rx_ph_q == (ovs_top >> 1) - 5'h01) begin
                            rx_ph_q <= 5'h00;
                            rx_st_q <= rx_s2_q ? ST_IDLE : ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (sync_mode || rx_ph_q == ovs_top - 5'h01) begin
                            rx_ph_q <= 5'h00;
                            rx_sh_q[rx_cnt_q] <= rx_s2_q;
                            if (rx_cnt_q == nbits - 4'h1) begin
                                rx_st_q <= ST_STOP;
                            end else begin
                                rx_cnt_q <= rx_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (sync_mode || rx_ph_q == ovs_top - 5'h01) begin
                            frame_err_q <= !rx_s2_q;
                            rxb_valid <= rxb_ready;
                            rx_st_q <= ST_IDLE;
                        end
                    end
                    default: rx_st_q <= ST_IDLE;
                endcase
            end
        end
    end

    ufb_buf2 u_rxbuf (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(rxb_valid),
        .in_ready(rxb_ready),
        .in_data(rx_sh_q),
        .out_valid(rxq_valid),
        .out_ready(rxq_ready),
        .out_data(rxq_data)
    );
endmodule // ufb_uart
